/* File: core/adc_cfg_consts.svh */
// constants for the converter configuration block: frame fields, codes, counts
//
// Overview of operation
// - both power bits set: full shutdown, keep registers
// - power 1,0: autoshutdown at 15th serial edge
// - power 0,1: autostandby at 15th edge, reference on
// - both power bits clear: everything always powered
// - equal sequencer bits: address picks next channel
// - sequencer 0,1: ascending masked channels, repeating
// - sequenced channels use their last written range
// - sequencer 1,0: channels zero to address, wrap
// - eight bit write-only mask, one per input
// - first range register holds channels 0-3 pairs
// - second range register holds channels 4-7 pairs
// - selected input takes its stored range automatically
// - range pair decodes 10V, 5V, 2.5V, unipolar
// - reset leaves every input at plus-minus 10V
// - power bits sit at control bits 7,6
// - sequencer bits sit at control bits 3,2
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

// serial frame geometry (word bit 15 arrives first)
`define FRAME_BITS 5'h10
`define POWER_EDGE 5'h0F
`define WORD_WRITE_BIT 15
`define WORD_SEL_HI 14
`define WORD_SEL_LO 13
`define PAYLOAD_HI 12
`define PAYLOAD_LO 5

// register select codes
`define SEL_CONTROL 2'h0
`define SEL_RANGE_LOW 2'h1
`define SEL_RANGE_HIGH 2'h2
`define SEL_SEQUENCE 2'h3

// control word fields
`define CTRL_ADDR_HI 12
`define CTRL_ADDR_LO 10
`define CTRL_POWER_HI 7
`define CTRL_POWER_LO 6
`define CTRL_SEQ_HI 3
`define CTRL_SEQ_LO 2

// write, select and power bits inside the partial shift register at the 15th edge
`define PARTIAL_WRITE_BIT 13
`define PARTIAL_SEL_HI 12
`define PARTIAL_SEL_LO 11
`define PARTIAL_POWER_HI 5
`define PARTIAL_POWER_LO 4

// reset values
`define RESET_RANGE 8'h00
`define RESET_MASK 8'h00
`define RESET_CHAN 3'h0

`endif

/* File: core/adc_cfg_pkg.sv */
// types shared by the converter configuration block
package adc_cfg_pkg;

    typedef enum logic [3:0] {
        PWR_NORMAL = 4'h1,
        PWR_AUTOSTANDBY = 4'h2,
        PWR_AUTOSHUTDOWN = 4'h4,
        PWR_FULL_SHUTDOWN = 4'h8
    } power_state_t;

    typedef enum logic [2:0] {
        SEQ_OFF = 3'h1,
        SEQ_MASK = 3'h2,
        SEQ_CONSECUTIVE = 3'h4
    } seq_mode_t;

    // decoded input range, one-hot
    typedef struct packed {
        logic unipolar_10v;
        logic bipolar_2v5;
        logic bipolar_5v;
        logic bipolar_10v;
    } range_sel_t;

    // serial-clock side: bit counter and partial word
    typedef struct packed {
        logic [4:0] count;
        logic [14:0] shift;
    } frame_t;

    // serial-clock side: values held for the system clock side
    typedef struct packed {
        logic start_toggle;
        logic power_toggle;
        logic end_toggle;
        logic [1:0] power_sel;
        logic [15:0] word;
    } handoff_t;

endpackage

/* File: core/adc_power_sequencer_range_config.sv */
// serial receiver plus power, sequencer and range configuration of the converter
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_consts.svh"

// ----------------------------------------------------------------------
// serial receiver, runs on the host's serial clock
// ----------------------------------------------------------------------
module adc_cfg_serial_rx
    import adc_cfg_pkg::*;
(
    input wire logic i_sclk,
    input wire logic i_sys_rst,
    input wire logic i_cs_n,
    input wire logic i_din,
    output var handoff_t o_handoff
);
    frame_t frame;
    frame_t next_frame;
    handoff_t hold;
    handoff_t next_hold;
    logic frame_rst;
    logic [15:0] full_word;

    // the serial clock stops between frames, so chip select clears the count
    assign frame_rst = i_sys_rst | i_cs_n;
    assign full_word = {frame.shift, i_din};

    // shift in msb first, freeze after the sixteenth bit
    always_comb begin
        next_frame = frame;
        if (frame.count != `FRAME_BITS) begin
            next_frame.shift = {frame.shift[13:0], i_din};
            next_frame.count = frame.count + 5'h01;
        end
    end

    // events toward the system clock travel as toggles with held data
    always_comb begin
        next_hold = hold;
        if (frame.count == 5'h00) begin
            next_hold.start_toggle = ~hold.start_toggle;
        end
        if (frame.count == (`POWER_EDGE - 5'h01) && frame.shift[`PARTIAL_WRITE_BIT]
            && frame.shift[`PARTIAL_SEL_HI:`PARTIAL_SEL_LO] == `SEL_CONTROL) begin
            next_hold.power_sel = frame.shift[`PARTIAL_POWER_HI:`PARTIAL_POWER_LO];
            next_hold.power_toggle = ~hold.power_toggle;
        end
        if (frame.count == (`FRAME_BITS - 5'h01)) begin
            next_hold.word = full_word;
            next_hold.end_toggle = ~hold.end_toggle;
        end
    end

    // chip select high parks the counter, so a cut frame never leaves
    // a half-counted word behind for the next one
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    // held values survive chip select, only system reset clears them
    always_ff @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold <= '0;
        end else begin
            hold <= next_hold;
        end
    end

    assign o_handoff = hold;
endmodule

// ----------------------------------------------------------------------
// configuration core, runs on the system clock
// ----------------------------------------------------------------------
module adc_power_sequencer_range_config
    import adc_cfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    output logic o_core_powered,
    output logic o_ref_powered,
    output logic o_full_shutdown,
    output logic o_seq_active,
    output logic [2:0] o_conv_chan,
    output logic [1:0] o_conv_range_code,
    output var range_sel_t o_conv_range
);
    typedef struct packed {
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] sync_c;
        power_state_t power;
        logic asleep;
        seq_mode_t seq_mode;
        logic [7:0] mask;
        logic [7:0] range_low;
        logic [7:0] range_high;
        logic [2:0] final_chan;
        logic [2:0] chan;
        logic [1:0] range_code;
        range_sel_t range_sel;
    } state_t;

    state_t st;
    state_t next_st;
    handoff_t handoff;
    logic [2:0] event_seen;
    logic [15:0] word;
    logic [1:0] sel;
    logic [1:0] seq_bits;

    adc_cfg_serial_rx u_rx (
        .i_sclk(i_sclk),
        .i_sys_rst(i_sys_rst),
        .i_cs_n(i_cs_n),
        .i_din(i_din),
        .o_handoff(handoff)
    );

    // toggles after two flops; bit 2 start, bit 1 power, bit 0 end of frame
    assign event_seen = st.sync_b ^ st.sync_c;
    // word and power bits stay put from their toggle until the next frame,
    // so they cross as held data once the toggle has passed both flops
    assign word = handoff.word;
    assign sel = word[`WORD_SEL_HI:`WORD_SEL_LO];
    assign seq_bits = word[`CTRL_SEQ_HI:`CTRL_SEQ_LO];

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // mask byte holds input 0 in its top bit
    function automatic logic chan_in_mask(input logic [7:0] m, input logic [2:0] c);
        chan_in_mask = m[3'h7 - c];
    endfunction

    // lowest flagged channel above a start point, wrapping
    function automatic logic [2:0] next_masked(input logic [7:0] m, input logic [2:0] from,
                                               input logic include_from);
        logic [2:0] pick;
        logic found;
        logic [2:0] c;
        pick = from;
        found = 1'b0;
        for (int i = 0; i < 8; i++) begin
            c = from + 3'(i);
            if (!found && (i != 0 || include_from) && chan_in_mask(m, c)) begin
                pick = c;
                found = 1'b1;
            end
        end
        if (!found && chan_in_mask(m, from)) begin
            pick = from;
        end
        next_masked = pick;
    endfunction

    function automatic logic [1:0] range_of(input logic [7:0] lo, input logic [7:0] hi,
                                            input logic [2:0] c);
        logic [7:0] r;
        logic [2:0] base;
        r = c[2] ? hi : lo;
        base = 3'h6 - {c[1:0], 1'b0};
        range_of = r[base +: 2];
    endfunction

    function automatic range_sel_t decode_range(input logic [1:0] code);
        range_sel_t d;
        d = '0;
        case (code)
            2'h0: d.bipolar_10v = 1'b1;
            2'h1: d.bipolar_5v = 1'b1;
            2'h2: d.bipolar_2v5 = 1'b1;
            default: d.unipolar_10v = 1'b1;
        endcase
        decode_range = d;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sync_a = {handoff.start_toggle, handoff.power_toggle, handoff.end_toggle};
        next_st.sync_b = st.sync_a;
        next_st.sync_c = st.sync_b;

        // auto modes wake for each conversion at frame start
        if (event_seen[2]) begin
            next_st.asleep = 1'b0;
        end

        // power change takes effect at the 15th serial edge
        if (event_seen[1]) begin
            case (handoff.power_sel)
                2'h3: next_st.power = PWR_FULL_SHUTDOWN;
                2'h2: next_st.power = PWR_AUTOSHUTDOWN;
                2'h1: next_st.power = PWR_AUTOSTANDBY;
                default: next_st.power = PWR_NORMAL;
            endcase
            next_st.asleep = handoff.power_sel[1] ^ handoff.power_sel[0];
        end

        // end of frame: one conversion done, then registers update
        if (event_seen[0]) begin
            // sequencer steps on every frame but a control write, which reloads the channel
            case (st.seq_mode)
                SEQ_MASK: next_st.chan = next_masked(st.mask, st.chan, 1'b0);
                SEQ_CONSECUTIVE: next_st.chan = (st.chan >= st.final_chan) ? 3'h0
                                                                          : st.chan + 3'h1;
                default: next_st.chan = st.chan;
            endcase
            if (word[`WORD_WRITE_BIT]) begin
                case (sel)
                    `SEL_CONTROL: begin
                        next_st.final_chan = word[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
                        if (seq_bits[1] == seq_bits[0]) begin
                            next_st.seq_mode = SEQ_OFF;
                            next_st.chan = word[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
                        end else if (seq_bits[0]) begin
                            next_st.seq_mode = SEQ_MASK;
                            next_st.chan = next_masked(st.mask, 3'h0, 1'b1);
                        end else begin
                            next_st.seq_mode = SEQ_CONSECUTIVE;
                            next_st.chan = 3'h0;
                        end
                    end
                    `SEL_SEQUENCE: next_st.mask = word[`PAYLOAD_HI:`PAYLOAD_LO];
                    `SEL_RANGE_LOW: next_st.range_low = word[`PAYLOAD_HI:`PAYLOAD_LO];
                    `SEL_RANGE_HIGH: next_st.range_high = word[`PAYLOAD_HI:`PAYLOAD_LO];
                    default: next_st.mask = st.mask;
                endcase
            end
        end

        // range follows the channel chosen for conversion
        next_st.range_code = range_of(next_st.range_low, next_st.range_high, next_st.chan);
        next_st.range_sel = decode_range(next_st.range_code);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // sync flops clear like the serial side, so no false event follows
            st <= '0;
            st.power <= PWR_NORMAL;
            st.seq_mode <= SEQ_OFF;
            st.mask <= `RESET_MASK;
            st.range_low <= `RESET_RANGE;
            st.range_high <= `RESET_RANGE;
            st.chan <= `RESET_CHAN;
            st.range_sel <= 4'h1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // normal keeps core up; power-down decode
    assign o_core_powered = (st.power == PWR_NORMAL) ||
                            (!st.asleep && st.power != PWR_FULL_SHUTDOWN);
    // autostandby keeps the reference alive for fast wake
    assign o_ref_powered = (st.power != PWR_FULL_SHUTDOWN) &&
                           !(st.power == PWR_AUTOSHUTDOWN && st.asleep);
    assign o_full_shutdown = (st.power == PWR_FULL_SHUTDOWN);
    // both sequencer modes count as active; off covers both equal codes
    assign o_seq_active = (st.seq_mode != SEQ_OFF);
    assign o_conv_chan = st.chan;
    assign o_conv_range_code = st.range_code;
    assign o_conv_range = st.range_sel;
endmodule
`default_nettype wire

/* File: testbench/adc_cfg_chk.sv */
// concurrent checks on the ports of the configuration block
`timescale 1ns/100ps
`default_nettype none
module adc_cfg_chk
    import adc_cfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic o_core_powered,
    input wire logic o_ref_powered,
    input wire logic o_full_shutdown,
    input wire logic o_seq_active,
    input wire logic [2:0] o_conv_chan,
    input wire logic [1:0] o_conv_range_code,
    input wire range_sel_t o_conv_range
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    AST_RANGE_ONEHOT: assert property (o_conv_range == (4'h1 << o_conv_range_code))
        else $error("range one-hot disagrees with range code");
    AST_FULL_ALL_DOWN: assert property (o_full_shutdown |-> !o_core_powered && !o_ref_powered)
        else $error("circuitry powered in full shutdown");
    AST_CORE_NEEDS_REF: assert property (o_core_powered |-> o_ref_powered && !o_full_shutdown)
        else $error("core powered without reference");
    AST_RESET_DEFAULTS: assert property ($fell(i_sys_rst) |-> o_core_powered && o_ref_powered
        && !o_full_shutdown && !o_seq_active && o_conv_chan == 3'h0
        && o_conv_range_code == 2'h0)
        else $error("wrong state after reset");
    // quiet link: channel, range code and core power may not move once a frame's update has landed
    AST_QUIET_HOLD: assert property (i_cs_n [*8] |=> $stable(o_conv_chan)
        && $stable(o_conv_range_code) && $stable(o_core_powered))
        else $error("state moved without a frame");
    AST_POWER_FROM_FRAME: assert property ($changed({o_core_powered, o_ref_powered,
        o_full_shutdown}) |-> !$past(i_cs_n, 6))
        else $error("power changed outside a frame");
    AST_CHAN_FROM_FRAME: assert property ($changed(o_conv_chan) |-> !$past(i_cs_n, 6))
        else $error("channel changed outside a frame");
    AST_SEQ_FROM_FRAME: assert property ($changed(o_seq_active) |-> !$past(i_cs_n, 6))
        else $error("sequencer changed outside a frame");
endmodule

bind adc_power_sequencer_range_config adc_cfg_chk u_chk (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_din(i_din),
    .o_core_powered(o_core_powered), .o_ref_powered(o_ref_powered),
    .o_full_shutdown(o_full_shutdown), .o_seq_active(o_seq_active),
    .o_conv_chan(o_conv_chan), .o_conv_range_code(o_conv_range_code),
    .o_conv_range(o_conv_range));
`default_nettype wire

/* File: testbench/host_link_model.sv */
// host controller model driving serial configuration frames
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
    input wire logic i_clk_sys,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end

    // link clock only runs inside a frame, 6 ns period, msb first
    // frame bit order
    task automatic send(input logic [15:0] w, input int edges);
        @(posedge i_clk_sys);
        #1 o_cs_n = 1'b0;
        #40.7;
        for (int i = 0; i < edges; i++) begin
            o_din = w[15 - i];
            #3 o_sclk = 1'b1;
            #3 o_sclk = 1'b0;
        end
        #3 o_cs_n = 1'b1;
        // released line shows the inverse so stale data never looks valid
        o_din = ~o_din;
        #20;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the converter configuration block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import adc_cfg_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    wire logic sclk, cs_n, din;
    logic core, refp, full, seqa;
    logic [2:0] chan_o;
    logic [1:0] code_o;
    range_sel_t rsel;
    int err_count = 0, comparisons = 0, cycles = 0;
    int mask = 0, mode = 0, addr = 0, pm = 0, chan = 0, rnd;
    int rng[8] = '{default: 0};

    always #4 i_clk_sys = ~i_clk_sys;

    host_link_model host (.i_clk_sys(i_clk_sys), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
    adc_power_sequencer_range_config dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_core_powered(core),
        .o_ref_powered(refp), .o_full_shutdown(full), .o_seq_active(seqa),
        .o_conv_chan(chan_o), .o_conv_range_code(code_o), .o_conv_range(rsel));

    // ----------------------------------------------------------------
    // model and checks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard: the 42 frames sent here fit well inside this
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask

    task automatic check();
        chk("channel", 8'(chan), {5'h00, chan_o});
        chk("range code", 8'(rng[chan]), {6'h00, code_o});
        chk("range one-hot", 8'(1 << rng[chan]), {4'h0, rsel});
        chk("sequencer", 8'(mode != 0), {7'h00, seqa});
        chk("power", {5'h00, pm == 0, pm < 2, pm == 3}, {5'h00, core, refp, full});
    endtask

    // next set mask bit above the current channel, wrapping; empty mask holds
    function automatic int next_masked(input int from);
        for (int k = 1; k <= 8; k++) begin
            if (mask[(from + k) % 8]) begin
                return (from + k) % 8;
            end
        end
        return from;
    endfunction

    task automatic frame(input logic [15:0] w, input int edges);
        host.send(w, edges);
        if (edges >= 15 && w[15] && w[14:13] == 2'h0) begin
            pm = w[7:6];
        end
        if (edges == 16 && w[15] && w[14:13] == 2'h0) begin
            addr = w[12:10];
            mode = (w[3:2] == 2'h1) ? 1 : (w[3:2] == 2'h2) ? 2 : 0;
            chan = (mode == 0) ? addr : (mode == 2) ? 0 : next_masked(7);
        end else if (edges == 16) begin
            // the sequencer steps on the old mask, then the write lands
            if (mode == 1) chan = next_masked(chan);
            if (mode == 2) chan = (chan == addr) ? 0 : chan + 1;
            if (w[15]) begin
                for (int i = 0; i < 8; i++) begin
                    if (w[14:13] == 2'h3) mask[i] = w[12 - i];
                    if (w[14:13] != 2'h3 && w[13 + i / 4]) rng[i] = w[12 - 2 * (i % 4) -: 2];
                end
            end
        end
        // look just after the edge so registered outputs have settled
        repeat (8) @(posedge i_clk_sys);
        #1;
    endtask

    function automatic logic [15:0] ctl(input int a, input int p, input int s);
        return {1'b1, 2'h0, 3'(a), 2'($urandom), 2'(p), 2'($urandom), 2'(s), 2'($urandom)};
    endfunction

    // payload frames carry random trailing bits that must be ignored
    function automatic logic [15:0] pay(input logic [1:0] sel, input logic [7:0] p);
        return {1'b1, sel, p, 5'($urandom)};
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge i_clk_sys);
        #1 i_sys_rst = 1'b0;
        rnd = $urandom(88035);
        check();
        frame(pay(2'h1, 8'($urandom)), 16);
        frame(pay(2'h2, 8'($urandom)), 16);
        for (int c = 0; c < 8; c++) begin
            frame(ctl(c, 0, c[0] ? 3 : 0), 16);
            check();
        end
        frame(pay(2'h3, 8'($urandom) | 8'h21), 16);
        frame(ctl($urandom % 8, 0, 1), 16);
        check();
        repeat (10) begin
            frame({1'b0, 15'($urandom)}, 16);
            check();
        end
        frame(ctl($urandom % 8, 0, 2), 16);
        check();
        repeat (12) begin
            frame({1'b0, 15'($urandom)}, 16);
            check();
        end
        for (int p = 3; p >= 0; p--) begin
            frame(ctl(6, p, 0), 16);
            check();
        end
        frame(ctl(5, 2, 0), 15);
        check();
        frame(ctl(5, 0, 0), 16);
        check();
        // a frame cut before the fifteenth edge changes nothing
        frame(ctl(3, 2, 0), 10);
        check();
        conclude();
    end
endmodule
`default_nettype wire
